/* File: core/ats_pkg.sv */
// Package: constants, register map and state types of the trigger and frame sequencer.
//
// Functional notes
// - Start event from one selected trigger source.
// - Every source performs identical start actions.
// - Internal generator: one-shot or repeating with delay.
// - Internal triggers on sample clock, own rate.
// - Trigger starts frame, 24-bit sample count.
// - After programmed samples, single halts, continuous awaits trigger.
// - Sample counter reloads automatically at frame end.
// - Software may disable counter for endless sampling.
// - FIFO flags depend only on fill level.
// - Interrupt on each completed frame when enabled.
// - Interrupt on FIFO half full when enabled.
// - Interrupt on bus-master block done when enabled.
// - Single mode one frame; continuous repeats frames.
// - Unlimited mode runs until host stops it.
// - Channel address advances as sample enters FIFO.
// - Single-channel addressing uses only selected channel.
// - Sequential addressing wraps after highest fitted channel.
// - Master drives its internal triggers on trigger output.
// - Sampling continues regardless of host reads.
// - FIFO word holds two samples, earlier low.
// - Sampling continues after trigger until count stored.
package ats_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_COUNT  = 5'h04;
  localparam logic [4:0] ADDR_DELAY  = 5'h08;
  localparam logic [4:0] ADDR_IRQEN  = 5'h0c;
  localparam logic [4:0] ADDR_IRQST  = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;
  localparam logic [4:0] ADDR_FIFO   = 5'h18;
  localparam logic [4:0] ADDR_STAT2  = 5'h1c;

  // ==========================================================
  // Control fields
  localparam int CTRL_START  = 0;
  localparam int CTRL_STOP   = 1;
  localparam int CTRL_SRC_LO = 2;
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_CNTDIS = 6;
  localparam int CTRL_SEQ    = 7;
  localparam int CTRL_CHS_LO = 8;
  localparam int CTRL_MASTER = 12;
  localparam int CTRL_W      = 13;

  localparam int IRQ_FRAME = 0;
  localparam int IRQ_HALF  = 1;
  localparam int IRQ_BLOCK = 2;
  localparam int IRQ_W     = 3;

  localparam logic [12:0] CTRL_RESET  = 13'h0000;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [23:0] DELAY_RESET = 24'h000000;

  // ==========================================================
  // FIFO geometry
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W      = 4;
  localparam logic [PTR_W:0] HALF_LEVEL = 5'h08;
  localparam logic [PTR_W:0] FULL_LEVEL = 5'h10;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {SRC_ANALOG, SRC_INTERNAL, SRC_EXTERNAL, SRC_NONE} ats_src_t;
  typedef enum logic [1:0] {MODE_SINGLE, MODE_CONT, MODE_FOREVER, MODE_RSVD} ats_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} ats_state_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ats_bus_t;

  typedef struct packed {
    ats_state_t                  state;
    logic [CTRL_W-1:0]           ctrl;
    logic [23:0]                 count;
    logic [23:0]                 delay;
    logic [IRQ_W-1:0]            irq_en;
    logic [IRQ_W-1:0]            irq_st;
    logic                        ovf;
    logic [23:0]                 cnt;
    logic [23:0]                 gen_cnt;
    logic                        gen_done;
    logic [3:0]                  chan;
    logic [15:0]                 low_half;
    logic                        low_valid;
    logic [FIFO_DEPTH-1:0][31:0] mem;
    logic [PTR_W-1:0]            wp;
    logic [PTR_W-1:0]            rp;
    logic [PTR_W:0]              lvl;
    logic                        half_d;
    logic [1:0]                  comp_s;
    logic [1:0]                  ext_s;
    logic                        comp_d;
    logic                        ext_d;
    logic [1:0][3:0]             top_s;
    logic [31:0]                 rdata;
    logic                        irq;
    logic                        trig_out;
    logic                        sampling;
  } ats_regs_t;

endpackage

/* File: core/ats_sequencer.sv */
// Trigger and frame sequencer: trigger select, sample counter, channel stepping and FIFO.
module ats_sequencer (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [4:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  input  wire logic        SAMPLE_TICK,
  input  wire logic [15:0] ADC_DATA,
  input  wire logic        COMP_TRIP,
  input  wire logic        EXT_TRIG,
  input  wire logic [3:0]  CHAN_TOP,
  input  wire logic        BLOCK_DONE,
  output logic      [3:0]  CHAN_ADDR,
  output logic             SAMPLING,
  output logic             TRIG_OUT,
  output logic             IRQ
);

  localparam int IRQ_W_L = ats_pkg::IRQ_W;

  ats_pkg::ats_regs_t r_reg;
  ats_pkg::ats_regs_t r_next;
  ats_pkg::ats_bus_t  bus;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  assign RDATA     = r_reg.rdata;
  assign CHAN_ADDR = r_reg.chan;
  assign SAMPLING  = r_reg.sampling;
  assign TRIG_OUT  = r_reg.trig_out;
  assign IRQ       = r_reg.irq;

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [1:0]            src;
    logic [1:0]            mode;
    logic                  unlimited;
    logic                  seq;
    logic [3:0]            chsel;
    logic [3:0]            top;
    logic                  comp_edge;
    logic                  ext_edge;
    logic                  int_trig;
    logic                  trig;
    logic                  take;
    logic                  push;
    logic                  pop;
    logic [31:0]           word;
    logic                  frame_end;
    logic                  half_now;
    logic [IRQ_W_L-1:0]    ev;
    logic [IRQ_W_L-1:0]    clr;
    src       = '0;
    mode      = '0;
    unlimited = 1'b0;
    seq       = 1'b0;
    chsel     = '0;
    top       = '0;
    comp_edge = 1'b0;
    ext_edge  = 1'b0;
    int_trig  = 1'b0;
    trig      = 1'b0;
    take      = 1'b0;
    push      = 1'b0;
    pop       = 1'b0;
    word      = '0;
    frame_end = 1'b0;
    half_now  = 1'b0;
    ev        = '0;
    clr       = '0;
    r_next    = r_reg;

    // Pins pass two flip-flops; only the second stage feeds logic.
    r_next.comp_s = {r_reg.comp_s[0], COMP_TRIP};
    r_next.ext_s  = {r_reg.ext_s[0], EXT_TRIG};
    r_next.top_s  = {r_reg.top_s[0], CHAN_TOP};
    r_next.comp_d = r_reg.comp_s[1];
    r_next.ext_d  = r_reg.ext_s[1];
    comp_edge = r_reg.comp_s[1] & ~r_reg.comp_d;
    ext_edge  = r_reg.ext_s[1] & ~r_reg.ext_d;
    top       = r_reg.top_s[1];

    src   = r_reg.ctrl[ats_pkg::CTRL_SRC_LO +: 2];
    mode  = r_reg.ctrl[ats_pkg::CTRL_MODE_LO +: 2];
    seq   = r_reg.ctrl[ats_pkg::CTRL_SEQ];
    chsel = r_reg.ctrl[ats_pkg::CTRL_CHS_LO +: 4];
    unlimited = (mode == 2'(ats_pkg::MODE_FOREVER)) | r_reg.ctrl[ats_pkg::CTRL_CNTDIS];

    // Internal generator counts sample ticks, so its triggers land on the
    // sample clock while the spacing is set by its own delay.
    r_next.trig_out = 1'b0;
    if (r_reg.state != ats_pkg::ST_IDLE && !r_reg.gen_done && SAMPLE_TICK) begin
      if (r_reg.gen_cnt == 24'h000000) begin
        int_trig       = 1'b1;
        r_next.gen_cnt = r_reg.delay;
        // Only continuous mode repeats; the others fire once per start.
        r_next.gen_done = (mode != 2'(ats_pkg::MODE_CONT));
      end else begin
        r_next.gen_cnt = r_reg.gen_cnt - 24'h000001;
      end
    end
    r_next.trig_out = int_trig & r_reg.ctrl[ats_pkg::CTRL_MASTER];

    // At most one source is looked at; SRC_NONE looks at none.
    case (src)
      2'(ats_pkg::SRC_ANALOG):   trig = comp_edge;
      2'(ats_pkg::SRC_INTERNAL): trig = int_trig;
      2'(ats_pkg::SRC_EXTERNAL): trig = ext_edge;
      default:                   trig = 1'b0;
    endcase

    // Sampling runs only in RUN; host reads never hold it.
    take = (r_reg.state == ats_pkg::ST_RUN) && SAMPLE_TICK;

    case (r_reg.state)
      ats_pkg::ST_IDLE: begin
      end
      ats_pkg::ST_ARMED: begin
        // One common start sequence for every source.
        if (trig) begin
          r_next.state = ats_pkg::ST_RUN;
          r_next.cnt   = r_reg.count;
          r_next.chan  = seq ? 4'h0 : chsel;
        end
      end
      ats_pkg::ST_RUN: begin
        // A trigger here neither restarts nor stretches the frame.
        if (take && !unlimited) begin
          if (r_reg.cnt == 24'h000000) begin
            frame_end = 1'b1;
            r_next.cnt = r_reg.count;
            // Single stops for good, continuous waits again.
            r_next.state = (mode == 2'(ats_pkg::MODE_CONT)) ? ats_pkg::ST_ARMED
                                                             : ats_pkg::ST_IDLE;
          end else begin
            r_next.cnt = r_reg.cnt - 24'h000001;
          end
        end
      end
      default: r_next.state = ats_pkg::ST_IDLE;
    endcase

    // Channel steps in the same cycle as the sample goes in.
    if (take) begin
      if (!seq) begin
        r_next.chan = chsel;
      end else if (r_reg.chan >= top) begin
        r_next.chan = 4'h0;
      end else begin
        r_next.chan = r_reg.chan + 4'h1;
      end
    end

    // Pair samples: the earlier one sits in the low half.
    if (take) begin
      if (r_reg.low_valid) begin
        push             = 1'b1;
        word             = {ADC_DATA, r_reg.low_half};
        r_next.low_valid = 1'b0;
      end else begin
        r_next.low_half  = ADC_DATA;
        r_next.low_valid = 1'b1;
      end
    end

    // ---- Register bus ----
    r_next.rdata = 32'h00000000;
    if (bus.wr) begin
      case (bus.addr)
        ats_pkg::ADDR_CTRL: begin
          r_next.ctrl = bus.wdata[ats_pkg::CTRL_W-1:0];
          r_next.ctrl[ats_pkg::CTRL_START] = 1'b0;
          r_next.ctrl[ats_pkg::CTRL_STOP]  = 1'b0;
          if (bus.wdata[ats_pkg::CTRL_STOP]) begin
            // Unlimited frames end only here or on a start write, which re-arms.
            r_next.state     = ats_pkg::ST_IDLE;
            r_next.low_valid = 1'b0;
          end else if (bus.wdata[ats_pkg::CTRL_START]) begin
            r_next.state     = ats_pkg::ST_ARMED;
            r_next.gen_cnt   = r_reg.delay;
            r_next.gen_done  = 1'b0;
            r_next.low_valid = 1'b0;
          end
        end
        ats_pkg::ADDR_COUNT: r_next.count = bus.wdata[23:0];
        ats_pkg::ADDR_DELAY: r_next.delay = bus.wdata[23:0];
        ats_pkg::ADDR_IRQEN: r_next.irq_en = bus.wdata[IRQ_W_L-1:0];
        ats_pkg::ADDR_IRQST: begin
          clr = bus.wdata[IRQ_W_L-1:0];
          if (bus.wdata[31]) begin
            r_next.ovf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        ats_pkg::ADDR_CTRL:   r_next.rdata = {19'h00000, r_reg.ctrl};
        ats_pkg::ADDR_COUNT:  r_next.rdata = {8'h00, r_reg.count};
        ats_pkg::ADDR_DELAY:  r_next.rdata = {8'h00, r_reg.delay};
        ats_pkg::ADDR_IRQEN:  r_next.rdata = {29'h00000000, r_reg.irq_en};
        ats_pkg::ADDR_IRQST:  r_next.rdata = {r_reg.ovf, 28'h0000000, r_reg.irq_st};
        ats_pkg::ADDR_STATUS: r_next.rdata = {8'h00, r_reg.cnt};
        ats_pkg::ADDR_FIFO: begin
          if (r_reg.lvl != 5'h00) begin
            pop          = 1'b1;
            r_next.rdata = r_reg.mem[r_reg.rp];
          end
        end
        default: r_next.rdata = 32'h00000000;
      endcase
    end
    if (bus.rd && bus.addr == ats_pkg::ADDR_STAT2) begin
      r_next.rdata = {16'h0000, r_reg.ovf, 2'h0, r_reg.lvl, r_reg.chan,
                      2'h0, r_reg.state};
    end

    // ---- FIFO ----
    if (push && r_reg.lvl == ats_pkg::FULL_LEVEL && !pop) begin
      // Word is lost; host sees the sticky overflow bit.
      r_next.ovf = 1'b1;
      push       = 1'b0;
    end
    if (push) begin
      r_next.mem[r_reg.wp] = word;
      r_next.wp            = r_reg.wp + 4'h1;
    end
    if (pop) begin
      r_next.rp = r_reg.rp + 4'h1;
    end
    r_next.lvl = r_reg.lvl + {4'h0, push} - {4'h0, pop};

    // Half-full comes from fill level alone, not frames.
    half_now      = (r_next.lvl >= ats_pkg::HALF_LEVEL);
    r_next.half_d = half_now;

    // ---- Interrupts ----
    ev[ats_pkg::IRQ_FRAME] = frame_end;
    ev[ats_pkg::IRQ_HALF]  = half_now & ~r_reg.half_d;
    ev[ats_pkg::IRQ_BLOCK] = BLOCK_DONE;
    for (int i = 0; i < IRQ_W_L; i++) begin
      // A new event beats a clear in the same cycle.
      r_next.irq_st[i] = ev[i] | (r_reg.irq_st[i] & ~clr[i]);
    end
    r_next.irq = |(r_next.irq_st & r_next.irq_en);

    r_next.sampling = (r_next.state == ats_pkg::ST_RUN);
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      r_reg       <= '0;
      r_reg.state <= ats_pkg::ST_IDLE;
      r_reg.ctrl  <= ats_pkg::CTRL_RESET;
      r_reg.count <= ats_pkg::COUNT_RESET;
      r_reg.delay <= ats_pkg::DELAY_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

/* File: bench/ats_sequencer_asserts.sv */
// Concurrent checks on the ports of the trigger and frame sequencer.
module ats_sequencer_asserts (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic [4:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        SAMPLE_TICK,
  input wire logic [15:0] ADC_DATA,
  input wire logic        COMP_TRIP,
  input wire logic        EXT_TRIG,
  input wire logic [3:0]  CHAN_TOP,
  input wire logic        BLOCK_DONE,
  input wire logic [3:0]  CHAN_ADDR,
  input wire logic        SAMPLING,
  input wire logic        TRIG_OUT,
  input wire logic        IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // ==========
  // Age of the last event that may set a pending bit; the bound allows for pipelining.
  logic [2:0] cause_age;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cause_age <= 3'h7;
    end else if (SAMPLE_TICK || BLOCK_DONE || WR) begin
      cause_age <= 3'h0;
    end else if (cause_age != 3'h7) begin
      cause_age <= cause_age + 3'h1;
    end
  end
  // ==========
  // Port relations.
  rdata_quiet_a: assert property (!$past(RD) |-> RDATA == 32'h0)
    else $error("read data outside the read slot");
  trig_tick_a: assert property (TRIG_OUT |-> $past(SAMPLE_TICK))
    else $error("trigger output not aligned to a sample tick");
  chan_step_a: assert property ($changed(CHAN_ADDR) |->
    ($past(SAMPLE_TICK) && $past(SAMPLING)) || $rose(SAMPLING))
    else $error("channel changed without a stored sample");
  chan_wrap_a: assert property (
    SAMPLING && $past(SAMPLING) && $past(SAMPLE_TICK) |->
    CHAN_ADDR == $past(CHAN_ADDR) || CHAN_ADDR == $past(CHAN_ADDR) + 4'h1 ||
    CHAN_ADDR == 4'h0)
    else $error("channel step is neither hold, increment nor wrap");
  run_holds_a: assert property (SAMPLING && !WR && !SAMPLE_TICK |=> SAMPLING)
    else $error("sampling stopped without a tick or a write");
  idle_still_a: assert property (!SAMPLING && SAMPLE_TICK ##1 !SAMPLING |->
    $stable(CHAN_ADDR))
    else $error("channel stepped while halted");
  irq_sticky_a: assert property ($fell(IRQ) |-> $past(WR))
    else $error("interrupt dropped without a write");
  irq_cause_a: assert property ($rose(IRQ) |-> cause_age <= 3'h5)
    else $error("interrupt raised without a recent cause");
endmodule

bind ats_sequencer ats_sequencer_asserts i_chk (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SAMPLE_TICK(SAMPLE_TICK),
  .ADC_DATA(ADC_DATA), .COMP_TRIP(COMP_TRIP), .EXT_TRIG(EXT_TRIG), .CHAN_TOP(CHAN_TOP),
  .BLOCK_DONE(BLOCK_DONE), .CHAN_ADDR(CHAN_ADDR), .SAMPLING(SAMPLING),
  .TRIG_OUT(TRIG_OUT), .IRQ(IRQ));

/* File: bench/ats_host.sv */
// Host model: register master that empties the sample FIFO in blocks.
module ats_host (
  input  wire logic        CLK,
  output logic      [4:0]  ADDR = 5'h00,
  output logic      [31:0] WDATA = 32'h0,
  output logic             WR = 1'b0,
  output logic             RD = 1'b0,
  input  wire logic [31:0] RDATA,
  output logic             BLOCK_DONE = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] words[$];
  logic        ovf_seen = 1'b0;
  // Released lines show the inverse so a stale value never looks valid.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK);
    WR    <= 1'b0;
    ADDR  <= ~a;
    WDATA <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK);
    RD   <= 1'b0;
    ADDR <= ~a;
    @(posedge CLK);
    d = RDATA;
  endtask
  task automatic stop();
    wr(ats_pkg::ADDR_CTRL, 32'h2);
  endtask
  task automatic pop_block(input int n);
    logic [31:0] d;
    rd(ats_pkg::ADDR_IRQST, d);
    ovf_seen = d[31];
    if (d[31]) wr(ats_pkg::ADDR_IRQST, 32'h80000000);
    repeat (n) begin
      rd(ats_pkg::ADDR_FIFO, d);
      words.push_back(d);
    end
    @(posedge CLK);
    BLOCK_DONE <= 1'b1;
    @(posedge CLK);
    BLOCK_DONE <= 1'b0;
  endtask
endmodule

/* File: bench/tb.sv */
// Testbench: triggers, frames, channel stepping, FIFO and interrupts of the sequencer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
  logic        CLK = 1'b0, RESET = 1'b1, SAMPLE_TICK = 1'b0, COMP_TRIP = 1'b0;
  logic        EXT_TRIG = 1'b0, tick_en = 1'b0, run_q = 1'b0;
  logic [15:0] ADC_DATA = 16'h0100;
  logic [3:0]  CHAN_TOP = 4'h2;
  logic [4:0]  ADDR;
  logic [31:0] WDATA, RDATA;
  logic        WR, RD, BLOCK_DONE, SAMPLING, TRIG_OUT, IRQ;
  logic [3:0]  CHAN_ADDR;
  int          fail_count = 0, checks = 0, ntrig = 0, nfr = 0;
  logic [15:0] smp[$];
  logic [3:0]  chq[$];
  always #12.5ns CLK = ~CLK;
  // ==========
  // Sample source and a record of what each stored sample should be.
  always @(posedge CLK) begin
    SAMPLE_TICK <= tick_en & ~SAMPLE_TICK;
    if (SAMPLE_TICK) ADC_DATA <= ADC_DATA + 16'h0001;
    if (SAMPLE_TICK && SAMPLING) begin
      smp.push_back(ADC_DATA);
      chq.push_back(CHAN_ADDR);
    end
    if (TRIG_OUT) ntrig++;
    if (SAMPLING && !run_q) nfr++;
    run_q <= SAMPLING;
  end
  ats_sequencer i_dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .SAMPLE_TICK(SAMPLE_TICK), .ADC_DATA(ADC_DATA),
    .COMP_TRIP(COMP_TRIP), .EXT_TRIG(EXT_TRIG), .CHAN_TOP(CHAN_TOP), .BLOCK_DONE(BLOCK_DONE),
    .CHAN_ADDR(CHAN_ADDR), .SAMPLING(SAMPLING), .TRIG_OUT(TRIG_OUT), .IRQ(IRQ));
  ats_host i_host (.CLK(CLK), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .BLOCK_DONE(BLOCK_DONE));
  // ==========
  // Scenarios.
  function automatic logic [31:0] ctl(input logic [1:0] src, input logic [1:0] mode,
                                      input logic seq, input logic [3:0] ch);
    return {19'h0, 1'b1, ch, seq, 1'b0, mode, src, 2'b01};
  endfunction
  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Pins are asynchronous, so the pulse is held long enough for the synchroniser.
  task automatic pin(input logic [1:0] sel);
    @(posedge CLK);
    {EXT_TRIG, COMP_TRIP} <= sel;
    repeat (3) @(posedge CLK);
    {EXT_TRIG, COMP_TRIP} <= 2'b00;
  endtask
  task automatic wait_run(input logic v);
    for (int i = 0; i < 300 && SAMPLING !== v; i++) @(negedge CLK);
    `CHK("sampling", v, SAMPLING)
  endtask
  task automatic frame_test(input logic [1:0] src, input logic seq, input logic [3:0] ch);
    logic [31:0] d;
    logic [1:0]  own;
    own = (src == 2'h0) ? 2'b01 : 2'b10;
    smp.delete();
    chq.delete();
    ntrig = 0;
    i_host.wr(ats_pkg::ADDR_CTRL, ctl(src, 2'h0, seq, ch));
    if (src != 2'h1) begin
      pin(~own);
      repeat (6) @(posedge CLK);
      `CHK("armed", 1'b0, SAMPLING)
      pin(own);
    end
    wait_run(1'b1);
    if (src != 2'h1) pin(own);
    wait_run(1'b0);
    repeat (20) @(posedge CLK);
    `CHK("halted", 1'b0, SAMPLING)
    `CHK("samples", 4, smp.size())
    // The generator runs once per start whatever the source, so the master pin pulses once.
    `CHK("trig out", 1, ntrig)
    for (int n = 0; n < 4; n++) `CHK("chan", (seq ? 4'(n % 3) : ch), chq[n])
    `CHK("frame irq", 1'b1, IRQ)
    i_host.rd(ats_pkg::ADDR_FIFO, d);
    `CHK("word 0", ({smp[1], smp[0]}), d)
    i_host.rd(ats_pkg::ADDR_FIFO, d);
    `CHK("word 1", ({smp[3], smp[2]}), d)
    i_host.wr(ats_pkg::ADDR_IRQST, 32'h1);
    repeat (2) @(posedge CLK);
    `CHK("irq cleared", 1'b0, IRQ)
    $display("frame test source %0d done", src);
  endtask
  task automatic forever_test();
    smp.delete();
    i_host.wr(ats_pkg::ADDR_IRQEN, 32'h2);
    i_host.wr(ats_pkg::ADDR_CTRL, ctl(2'h2, 2'h2, 1'b1, 4'h0));
    pin(2'b10);
    wait_run(1'b1);
    repeat (80) @(posedge CLK);
    i_host.pop_block(3);
    `CHK("no pause", 1'b1, SAMPLING)
    `CHK("overflow", 1'b1, i_host.ovf_seen)
    `CHK("endless", 1'b1, smp.size() > 8)
    `CHK("half irq", 1'b1, IRQ)
    i_host.stop();
    wait_run(1'b0);
    i_host.wr(ats_pkg::ADDR_IRQST, 32'h80000007);
    i_host.wr(ats_pkg::ADDR_IRQEN, 32'h4);
    repeat (2) @(posedge CLK);
    `CHK("irq idle", 1'b0, IRQ)
    i_host.pop_block(2);
    repeat (6) @(posedge CLK);
    `CHK("block irq", 1'b1, IRQ)
    $display("forever test done");
  endtask
  task automatic cntdis_test();
    i_host.wr(ats_pkg::ADDR_CTRL, ctl(2'h3, 2'h0, 1'b0, 4'h1));
    pin(2'b11);
    repeat (6) @(posedge CLK);
    `CHK("no source", 1'b0, SAMPLING)
    i_host.wr(ats_pkg::ADDR_CTRL, ctl(2'h1, 2'h0, 1'b0, 4'h1) | 32'h40);
    wait_run(1'b1);
    repeat (40) @(posedge CLK);
    `CHK("counter off", 1'b1, SAMPLING)
    i_host.stop();
    wait_run(1'b0);
    $display("counter disable test done");
  endtask
  task automatic cont_test();
    i_host.wr(ats_pkg::ADDR_IRQEN, 32'h1);
    ntrig = 0;
    nfr = 0;
    i_host.wr(ats_pkg::ADDR_CTRL, ctl(2'h1, 2'h1, 1'b0, 4'h3));
    repeat (200) @(posedge CLK);
    `CHK("repeats", 1'b1, nfr > 4 && ntrig >= nfr)
    i_host.stop();
    wait_run(1'b0);
    $display("continuous test done");
  endtask
  initial begin
    repeat (10) @(posedge CLK);
    RESET <= 1'b0;
    repeat (4) @(posedge CLK);
    tick_en <= 1'b1;
    i_host.wr(ats_pkg::ADDR_COUNT, 32'h3);
    i_host.wr(ats_pkg::ADDR_DELAY, 32'h2);
    i_host.wr(ats_pkg::ADDR_IRQEN, 32'h1);
    for (int s = 0; s < 3; s++) frame_test(2'(s), s != 2, 4'h5);
    forever_test();
    cntdis_test();
    cont_test();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    close_out();
  end
endmodule
